// *** hdl/scp_pkg.sv ***
// constants and types shared by the sensor conditioner test port
package scp_pkg;

   // -------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;   // 250 MHz system clock
   localparam int EOC_PULSE_NS  = 1000;   // end-of-conversion high time
   // least time, rounded up to whole cycles
   localparam int EOC_PULSE_CYC = (EOC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EOC_CNT_W     = $clog2(EOC_PULSE_CYC + 1);

   // -------------------------------------------------------------
   // word widths
   // -------------------------------------------------------------
   localparam int DATA_W     = 12;        // parallel result, bit 11 is msb
   localparam int ROM_ADDR_W = 10;        // dsp instruction rom address
   localparam int ROM_DATA_W = 16;        // dsp instruction rom data
   localparam int DSP_RES_W  = 16;        // dsp instruction result
   localparam int FRAME_W    = ROM_ADDR_W + ROM_DATA_W;
   localparam int FRAME_CW   = $clog2(FRAME_W);
   localparam int RES_CW     = $clog2(DSP_RES_W);

   // -------------------------------------------------------------
   // test commands
   // -------------------------------------------------------------
   localparam int          CMD_W       = 4;
   localparam int          CMD_CW      = $clog2(CMD_W);
   localparam logic [3:0]  CMD_TRACE_A = 4'h8;   // turn serial line to output
   localparam logic [3:0]  CMD_TRACE_B = 4'hA;   // same, second code

   // -------------------------------------------------------------
   // synchroniser lanes for pin inputs
   // -------------------------------------------------------------
   localparam int SYNC_W  = 6;
   localparam int SY_SELA = 0;
   localparam int SY_SELB = 1;
   localparam int SY_TEST = 2;
   localparam int SY_RST  = 3;
   localparam int SY_STRT = 4;
   localparam int SY_SDIO = 5;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   // reset pin lane starts at its pulled-up idle level, so no false rise
   localparam logic [SYNC_W-1:0] SYNC_RST = 6'h08;
   localparam logic [DATA_W-1:0] DATA_RST = 12'h000;

   // command receiver states, one-hot
   typedef enum logic [2:0] {
      CMD_IDLE  = 3'b001,
      CMD_SHIFT = 3'b010,
      CMD_EXEC  = 3'b100
   } scp_cmd_state_t;

endpackage : scp_pkg

// *** hdl/scp_test_port.sv ***
// digital pin logic and serial test port of the sensor conditioner
`timescale 1ns/1ps

module scp_test_port
   import scp_pkg::*;
(
   // clock, enable and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  ce_i,
   input  wire logic                  rst_n_i,
   // pins from outside
   input  wire logic                  select_a_in_i,
   input  wire logic                  select_b_in_i,
   input  wire logic                  test_mode_i,
   input  wire logic                  reset_pin_n_i,
   input  wire logic                  start_i,
   input  wire logic                  sdio_i,
   // serial test line, two-way
   output logic                       sdio_o,
   output logic                       sdio_oe_n_o,
   // serial test output
   output logic                       test_serial_out_o,
   output logic                       test_serial_out_oe_n_o,
   // parallel result and end of conversion
   output logic [DATA_W-1:0]          data_o,
   output logic                       data_oe_n_o,
   output logic                       eoc_o,
   output logic                       eoc_oe_n_o,
   // dsp core, same clock
   input  wire logic [ROM_ADDR_W-1:0] rom_addr_i,
   input  wire logic [ROM_DATA_W-1:0] rom_data_i,
   input  wire logic [DSP_RES_W-1:0]  dsp_result_i,
   input  wire logic [DATA_W-1:0]     conv_result_i,
   input  wire logic                  conv_done_i,
   output logic                       conv_req_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0]              rst_sync_r;     // reset release chain
   logic                    rst_n;          // released reset
   logic [SYNC_W-1:0]       sync1_r;        // first stage, read only by second
   logic [SYNC_W-1:0]       sync2_r;        // pins in the clock domain
   logic                    sel;            // both selects high
   logic                    test_on;        // selected and in test mode
   logic                    rst_pin_d_r;    // reset pin, one cycle late
   logic                    armed_r;        // commands accepted
   scp_cmd_state_t          cmd_state_r;    // command receiver state
   logic [CMD_W-1:0]        cmd_sh_r;       // command shift register
   logic [CMD_CW-1:0]       cmd_cnt_r;      // command bit count
   logic                    drive_r;        // trace command seen
   logic                    hold_off_r;     // floated since deselect
   logic                    sdio_act;       // serial line is driven
   logic [FRAME_W-1:0]      frame_sh_r;     // address and data frame
   logic [FRAME_CW-1:0]     frame_cnt_r;    // frame bit count
   logic [DSP_RES_W-1:0]    res_sh_r;       // result word shifter
   logic [RES_CW-1:0]       res_cnt_r;      // result bit count
   logic                    busy_r;         // conversion in flight
   logic                    conv_go;        // start a conversion now
   logic [DATA_W-1:0]       data_r;         // held result word
   logic [EOC_CNT_W-1:0]    eoc_cnt_r;      // eoc high time left

   // trace commands that turn the serial line round
   function automatic logic is_trace_cmd(input logic [CMD_W-1:0] cmd);
      is_trace_cmd = (cmd == CMD_TRACE_A) || (cmd == CMD_TRACE_B);
   endfunction : is_trace_cmd

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   // reset release runs even with ce low so reset always completes
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // every pin passes two flops; the tester clock is our clock here
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else if (ce_i) begin
         sync1_r <= {sdio_i, start_i, reset_pin_n_i, test_mode_i,
                     select_b_in_i, select_a_in_i};
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------------------------------
   // selection
   // ----------------------------------------------------------------
   assign sel     = sync2_r[SY_SELA] & sync2_r[SY_SELB];
   // every pin input below is qualified by sel, so a deselected part ignores them
   assign test_on = sel & sync2_r[SY_TEST];

   // ----------------------------------------------------------------
   // command arming by the reset pin
   // ----------------------------------------------------------------
   // a low-to-high step on the pin arms; leaving test mode disarms
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         rst_pin_d_r <= SYNC_RST[SY_RST];   // idle high, matches the lane
         armed_r     <= 1'b0;
      end else if (ce_i) begin
         rst_pin_d_r <= sync2_r[SY_RST];
         if (!test_on) begin
            armed_r <= 1'b0;
         end else if (sync2_r[SY_RST] && !rst_pin_d_r) begin
            armed_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // command receiver: start bit, then four bits msb first
   // ----------------------------------------------------------------
   // the line cannot listen while it is driven, so reception waits
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_state_r <= CMD_IDLE;
         cmd_sh_r    <= '0;
         cmd_cnt_r   <= '0;
      end else if (ce_i) begin
         unique case (cmd_state_r)
            CMD_IDLE: begin
               // start bit seen on an armed, listening line
               if (armed_r && !sdio_act && sync2_r[SY_SDIO]) begin
                  cmd_state_r <= CMD_SHIFT;
                  cmd_cnt_r   <= '0;
               end
            end
            CMD_SHIFT: begin
               cmd_sh_r  <= {cmd_sh_r[CMD_W-2:0], sync2_r[SY_SDIO]};
               cmd_cnt_r <= cmd_cnt_r + 1'b1;
               if (!armed_r) begin
                  cmd_state_r <= CMD_IDLE;   // abandon on leaving test mode
               end else if (cmd_cnt_r == CMD_CW'(CMD_W - 1)) begin
                  cmd_state_r <= CMD_EXEC;
               end
            end
            CMD_EXEC: begin
               cmd_state_r <= CMD_IDLE;
            end
            default: begin
               cmd_state_r <= CMD_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // serial line direction
   // ----------------------------------------------------------------
   // trace command turns the line to output; leaving test mode, deselect, or a non-trace command taken while held off returns it
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         drive_r <= 1'b0;
      end else if (ce_i) begin
         if (!test_on) begin
            drive_r <= 1'b0;
         end else if (cmd_state_r == CMD_EXEC) begin
            drive_r <= is_trace_cmd(cmd_sh_r);
         end
      end
   end

   // deselect floats the line until a conversion is started
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         hold_off_r <= 1'b0;
      end else if (ce_i) begin
         if (!sel) begin
            hold_off_r <= 1'b1;
         end else if (conv_go) begin
            hold_off_r <= 1'b0;
         end
      end
   end

   assign sdio_act    = drive_r & ~hold_off_r & test_on;
   assign sdio_oe_n_o = ~sdio_act;

   // ----------------------------------------------------------------
   // trace frame: rom address then rom data, msb first
   // ----------------------------------------------------------------
   // sampled at frame start, so a frame is one coherent instruction
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_sh_r  <= '0;
         frame_cnt_r <= '0;
      end else if (ce_i) begin
         if (!sdio_act) begin
            frame_cnt_r <= '0;
         end else if (frame_cnt_r == '0) begin
            frame_sh_r  <= {rom_addr_i, rom_data_i};
            frame_cnt_r <= FRAME_CW'(1);
         end else begin
            frame_sh_r  <= {frame_sh_r[FRAME_W-2:0], 1'b0};
            frame_cnt_r <= (frame_cnt_r == FRAME_CW'(FRAME_W - 1)) ?
                           '0 : frame_cnt_r + 1'b1;
         end
      end
   end
   assign sdio_o = frame_sh_r[FRAME_W-1];

   // ----------------------------------------------------------------
   // result stream on the serial test output
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         res_sh_r  <= '0;
         res_cnt_r <= '0;
      end else if (ce_i) begin
         if (!test_on) begin
            res_cnt_r <= '0;
         end else if (res_cnt_r == '0) begin
            res_sh_r  <= dsp_result_i;
            res_cnt_r <= RES_CW'(1);
         end else begin
            res_sh_r  <= {res_sh_r[DSP_RES_W-2:0], 1'b0};
            res_cnt_r <= res_cnt_r + 1'b1;   // wraps at word end
         end
      end
   end
   assign test_serial_out_o      = res_sh_r[DSP_RES_W-1];
   assign test_serial_out_oe_n_o = ~test_on;

   // ----------------------------------------------------------------
   // conversion start
   // ----------------------------------------------------------------
   // start is pulled high off chip, so an open pin converts freely;
   // holding it low delays conversion to stretch sensor warm-up
   assign conv_go = sel & sync2_r[SY_STRT] & ~busy_r;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_r     <= 1'b0;
         conv_req_o <= 1'b0;
      end else if (ce_i) begin
         conv_req_o <= conv_go;
         if (conv_go) begin
            busy_r <= 1'b1;
         end else if (conv_done_i) begin
            busy_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // result word and end-of-conversion pulse
   // ----------------------------------------------------------------
   // word is loaded on the same edge that raises eoc and stays put past its fall
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         data_r    <= DATA_RST;
         eoc_cnt_r <= '0;
      end else if (ce_i) begin
         if (busy_r && conv_done_i) begin
            data_r    <= conv_result_i;
            eoc_cnt_r <= EOC_CNT_W'(EOC_PULSE_CYC);
         end else if (eoc_cnt_r != '0) begin
            eoc_cnt_r <= eoc_cnt_r - 1'b1;
         end
      end
   end

   assign data_o      = data_r;
   assign data_oe_n_o = ~sel;
   assign eoc_o       = (eoc_cnt_r != '0);
   assign eoc_oe_n_o  = ~sel;

endmodule : scp_test_port

// *** testbench/scp_test_port_asserts.sv ***
// concurrent checks on the sensor conditioner test port pins
`timescale 1ns/1ps
module scp_test_port_asserts
   import scp_pkg::*;
(
   // clock and reset
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   // watched pins
   input wire logic              select_a_in_i,
   input wire logic              select_b_in_i,
   input wire logic              test_mode_i,
   input wire logic              start_i,
   input wire logic [DATA_W-1:0] conv_result_i,
   input wire logic [DATA_W-1:0] data_o,
   input wire logic              data_oe_n_o,
   input wire logic              eoc_o,
   input wire logic              eoc_oe_n_o,
   input wire logic              sdio_oe_n_o,
   input wire logic              test_serial_out_oe_n_o,
   input wire logic              conv_req_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // -------------------------------------------------------------
   // helper: cycles the end-of-conversion pulse has stood high
   // -------------------------------------------------------------
   int eoc_cnt_r;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) eoc_cnt_r <= 0;
      else eoc_cnt_r <= eoc_o ? eoc_cnt_r + 1 : 0;
   end
   // request pulse is a single cycle
   sequence s_req_seen;
      $past(start_i, 3) && $past(select_a_in_i, 3) && $past(select_b_in_i, 3);
   endsequence
   sequence s_req_drop; conv_req_o ##1 !conv_req_o; endsequence
   property p_sel_oe; !data_oe_n_o |-> $past(select_a_in_i, 2) && $past(select_b_in_i, 2); endproperty
   a_sel_oe: assert property (p_sel_oe) else $error("outputs driven while not selected");
   // deselected: every output enable must be off together
   property p_oe_same;
      data_oe_n_o |-> eoc_oe_n_o && sdio_oe_n_o && test_serial_out_oe_n_o;
   endproperty
   a_oe_same: assert property (p_oe_same) else $error("output driven while deselected");
   property p_tso_test; !test_serial_out_oe_n_o |-> $past(test_mode_i, 2) && !data_oe_n_o; endproperty
   a_tso_test: assert property (p_tso_test) else $error("serial out driven outside test");
   property p_sdio_sel; !sdio_oe_n_o |-> !data_oe_n_o && $past(test_mode_i, 2); endproperty
   a_sdio_sel: assert property (p_sdio_sel) else $error("serial line driven when not allowed");
   property p_eoc_len; $fell(eoc_o) |-> eoc_cnt_r == EOC_PULSE_CYC; endproperty
   a_eoc_len: assert property (p_eoc_len) else $error("eoc pulse length wrong");
   property p_data_hold; $past(eoc_o) |-> $stable(data_o); endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved during eoc");
   property p_data_val; $rose(eoc_o) |-> data_o == $past(conv_result_i); endproperty
   a_data_val: assert property (p_data_val) else $error("result word wrong");
   property p_req; conv_req_o |-> s_req_seen ##0 s_req_drop; endproperty
   a_req: assert property (p_req) else $error("conversion request without start");
endmodule : scp_test_port_asserts
bind scp_test_port scp_test_port_asserts chk_u (.*);

// *** testbench/scp_host_model.sv ***
// test system model: drives commands on the serial line
`timescale 1ns/1ps
module scp_host_model (
   input  wire logic clk_sys_i,
   input  wire logic sdio_o,
   input  wire logic sdio_oe_n_o,
   output logic      sdio_i
);
   logic host_drv = 0; // host owns the line
   logic host_val = 0;
   // wire level: device, host, else pull-down
   assign sdio_i = !sdio_oe_n_o ? sdio_o : (host_drv ? host_val : 1'b0);
   // start bit then four bits msb first
   task automatic send_cmd(input logic [3:0] c);
      @(negedge clk_sys_i);
      host_drv = 1;
      host_val = 1;
      for (int i = 3; i >= 0; i--) begin
         @(negedge clk_sys_i);
         host_val = c[i];
      end
      @(negedge clk_sys_i);
      host_drv = 0;
   endtask : send_cmd
endmodule : scp_host_model

// *** testbench/scp_test_port_tb.sv ***
// self-checking bench for the sensor conditioner test port
`timescale 1ns/1ps
module scp_test_port_tb;
   import scp_pkg::*;
   // -------------------------------------------------------------
   // pins and dsp side
   // -------------------------------------------------------------
   logic                  clk_sys_i = 0;
   logic                  rst_n_i   = 0;
   logic                  sel_a = 0, sel_b = 0, test_m = 0, rpin_n = 1, start = 0, done = 0;
   logic [DATA_W-1:0]     conv_res = 12'h000;
   logic [ROM_ADDR_W-1:0] rom_a = 10'h2D5;
   logic [ROM_DATA_W-1:0] rom_d = 16'h9E17;
   logic [DSP_RES_W-1:0]  dsp_r = 16'hC3A1;
   logic sdio_i, sdio_o, sdio_oe_n_o, tso, tso_oe_n, eoc_o, eoc_oe_n, data_oe_n_o, conv_req_o;
   logic [DATA_W-1:0]     data_o;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   scp_test_port dut_u (.clk_sys_i(clk_sys_i), .ce_i(1'b1), .rst_n_i(rst_n_i),
      .select_a_in_i(sel_a), .select_b_in_i(sel_b), .test_mode_i(test_m),
      .reset_pin_n_i(rpin_n), .start_i(start), .sdio_i(sdio_i), .sdio_o(sdio_o),
      .sdio_oe_n_o(sdio_oe_n_o), .test_serial_out_o(tso), .test_serial_out_oe_n_o(tso_oe_n),
      .data_o(data_o), .data_oe_n_o(data_oe_n_o), .eoc_o(eoc_o), .eoc_oe_n_o(eoc_oe_n),
      .rom_addr_i(rom_a), .rom_data_i(rom_d), .dsp_result_i(dsp_r),
      .conv_result_i(conv_res), .conv_done_i(done), .conv_req_o(conv_req_o));
   scp_host_model host_u (.clk_sys_i(clk_sys_i), .sdio_o(sdio_o),
      .sdio_oe_n_o(sdio_oe_n_o), .sdio_i(sdio_i));
   // 50% duty clock, as a tester gives it
   initial forever #2 clk_sys_i = ~clk_sys_i;
   // hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   // -------------------------------------------------------------
   // shared helpers
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc_n
   // wait for a flag, bounded
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 60 && s !== v; i++) @(negedge clk_sys_i);
   endtask : wait_for
   // a stream word repeats, so any rotation of it is a match
   function automatic logic in_rot(input logic [25:0] s, input logic [25:0] e, input int n);
      logic [25:0] m;
      m = (26'h1 << n) - 1;
      in_rot = 0;
      for (int k = 0; k < n; k++) if ((((e << k) | (e >> (n - k))) & m) == (s & m)) in_rot = 1;
   endfunction : in_rot
   // arm command reception with a reset pin rise
   task automatic arm;
      rpin_n = 0;
      cyc_n(4);
      rpin_n = 1;
      cyc_n(4);
   endtask : arm
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset;
      chk("data_oe_n", data_oe_n_o, 1);
      chk("sdio_oe_n", sdio_oe_n_o, 1);
      chk("tso_oe_n", tso_oe_n, 1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_conv;
      sel_a = 1;
      sel_b = 1;
      start = 1;
      conv_res = 12'hA5C;
      wait_for(conv_req_o, 1);
      chk("conv_req", conv_req_o, 1);
      start = 0;
      cyc_n(3);
      chk("data_oe_n", data_oe_n_o, 0);
      done = 1;
      cyc_n(1);
      done = 0;
      conv_res = 12'h000;
      chk("data", data_o, 12'hA5C);
      cyc_n(EOC_PULSE_CYC - 1);
      chk("eoc_high", eoc_o, 1);
      cyc_n(1);
      chk("eoc_low", eoc_o, 0);
      chk("data_hold", data_o, 12'hA5C);
      $display("test conversion done");
   endtask : t_conv
   task automatic t_trace;
      logic [25:0] s;
      test_m = 1;
      arm();
      chk("tso_oe_n", tso_oe_n, 0);
      for (int i = 0; i < 16; i++) begin s = {s[24:0], tso}; cyc_n(1); end
      chk("tso_word", in_rot(s, {10'h0, dsp_r}, 16), 1);
      host_u.send_cmd(4'h3);
      cyc_n(6);
      chk("sdio_other", sdio_oe_n_o, 1);
      host_u.send_cmd(4'h8);
      wait_for(sdio_oe_n_o, 0);
      chk("sdio_drive", sdio_oe_n_o, 0);
      cyc_n(2);
      for (int i = 0; i < 26; i++) begin s = {s[24:0], sdio_i}; cyc_n(1); end
      chk("frame", in_rot(s, {rom_a, rom_d}, 26), 1);
      test_m = 0;
      cyc_n(4);
      chk("sdio_test_low", sdio_oe_n_o, 1);
      chk("tso_test_low", tso_oe_n, 1);
      $display("test trace done");
   endtask : t_trace
   task automatic t_holdoff;
      test_m = 1;
      sel_b = 0;
      cyc_n(4);
      chk("desel_data", data_oe_n_o, 1);
      chk("desel_tso", tso_oe_n, 1);
      sel_b = 1;
      arm();
      host_u.send_cmd(4'hA);
      cyc_n(8);
      chk("held_off", sdio_oe_n_o, 1);
      start = 1;
      wait_for(conv_req_o, 1);
      start = 0;
      done = 1;
      cyc_n(1);
      done = 0;
      cyc_n(4);
      // the earlier trace command turns the line round at conversion start;
      // the host must not send into a line the device already drives
      chk("drive_a", sdio_oe_n_o, 0);
      $display("test hold-off done");
   endtask : t_holdoff
   // -------------------------------------------------------------
   // verdict, the only exit
   // -------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      cyc_n(6);
      rst_n_i = 1;
      cyc_n(4);
      t_reset();
      t_conv();
      t_trace();
      t_holdoff();
      final_report();
   end
endmodule : scp_test_port_tb
